// ===== core/sstwu_pkg.sv
package sstwu_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SSTWU_CLK_PERIOD_NS = 10;
  localparam int SSTWU_SDA_DELAY_MIN_NS = 50;
  localparam int SSTWU_SDA_DELAY_MAX_NS = 300;
  // least delay rounds up to whole cycles
  localparam int SSTWU_SDA_DELAY_CYC =
    (SSTWU_SDA_DELAY_MIN_NS + SSTWU_CLK_PERIOD_NS - 1) / SSTWU_CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // field values
  // ---------------------------------------------------------------
  localparam int SSTWU_MSB = 7;
  localparam logic [7:0] SSTWU_SHIFT_RESET = 8'h00;
  localparam logic [3:0] SSTWU_COUNT_RESET = 4'h0;
  localparam logic [3:0] SSTWU_COUNT_TOP = 4'hf;
  localparam logic [3:0] SSTWU_COUNT_STEP = 4'h1;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSTWU_WM_OFF = 2'b00,
    SSTWU_WM_THREE = 2'b01,
    SSTWU_WM_TWO = 2'b10,
    SSTWU_WM_TWO_HOLD = 2'b11
  } sstwu_wire_mode_t;

  typedef enum logic [1:0] {
    SSTWU_CS_SOFT = 2'b00,
    SSTWU_CS_TIMER = 2'b01,
    SSTWU_CS_EXT_POS = 2'b10,
    SSTWU_CS_EXT_NEG = 2'b11
  } sstwu_clk_src_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    sstwu_wire_mode_t wire_mode;
    sstwu_clk_src_t clock_source;
    logic strobe_counts;
  } sstwu_ctrl_t;

  typedef struct packed {
    logic clock_strobe;
    logic toggle_strobe;
    logic data_write;
    logic [7:0] data_wdata;
    logic count_write;
    logic [3:0] count_wdata;
    logic clear_start;
    logic clear_overflow;
    logic clear_stop;
  } sstwu_cmd_t;

  typedef struct packed {
    logic [7:0] serial_shift_register;
    logic [3:0] count;
    logic start_detected_flag;
    logic count_overflow_flag;
    logic stop_seen_flag;
    logic collision;
  } sstwu_status_t;

endpackage

// ===== core/sstwu_core.sv
`timescale 1ns/1ps
// What this block does
// - two-wire pins have no slew limit or filter; protocol steers direction
// - master makes the clock; only the slave holds it; shifting is automatic
// - shifting is on the falling clock edge only with SSTWU_CS_EXT_NEG, in any wire mode
// - slave may add wait states by holding the clock line low
// - every serial clock also advances the counter unless strobe_counts is set; overflow ends a transfer
// - start detector sets the start flag on a start condition
// - after start and a falling clock edge, clock held low until flag cleared
// - slave samples data into the shift register on rising clock edges
// - after eight address bits the counter overflows and, in SSTWU_WM_TWO_HOLD mode, clock is held low
// - unaddressed slave releases clock and waits for next start
// - addressed slave drives data low to acknowledge; counter preset to 14
// - direction bit one means slave drives data, else master drives
// - any number of bytes follow until stop or repeated start
// - slave that cannot take more data withholds acknowledge
// - data line delayed 50 to 300 ns before the start check
// - start detector active only in two-wire mode
// - start detector must work without waiting on processor activity
// - counter usable alone; external clock counts both edges, or toggle strobes when strobe_counts is set
// - counter clocked by timer match forms a 12-bit chain
// - counter preset to F overflows on next edge or soft strobe
// - overflow flag sets when the counter wraps from top to zero
// - clearing start flag clears it and releases the start hold
// - clearing overflow flag clears it and releases the overflow hold
// - stop condition sets stop flag, cleared by writing one
module sstwu_core
(
  // system clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // serial clock line used as link clock
  input wire logic scl_clk_in,
  // configuration and commands
  input wire sstwu_pkg::sstwu_ctrl_t ctrl_in,
  input wire sstwu_pkg::sstwu_cmd_t cmd_in,
  input wire logic timer_match_in,
  input wire logic port_scl_low_in,
  input wire logic port_sda_low_in,
  // status
  output sstwu_pkg::sstwu_status_t status_out,
  // two-wire pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // three-wire data output
  output logic data_pin_out
);
  import sstwu_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sda_bit;
    logic rise_tgl;
  } sstwu_link_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [2:0] tgl_sync;
    logic [SSTWU_SDA_DELAY_CYC-1:0] sda_dly;
    logic scl_prev;
    logic start_hold;
    logic latch_msb;
    sstwu_status_t st;
    logic scl_oe;
    logic sda_oe;
    logic scl_pin;
    logic sda_pin;
    logic data_pin;
  } sstwu_state_t;

  sstwu_link_t lnk;
  sstwu_link_t next_lnk;
  sstwu_state_t s;
  sstwu_state_t next_s;

  logic two_wire;
  logic ext_clk;
  logic scl_lvl;
  logic sda_lvl;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic shift_tick;
  logic cnt_tick;
  logic wrap;
  logic in_bit;

  // ---------------------------------------------------------------
  // link domain: capture data on each rising serial clock
  // ---------------------------------------------------------------
  always_comb
  begin
    next_lnk = lnk;
    next_lnk.sda_bit = sda_in;
    next_lnk.rise_tgl = ~lnk.rise_tgl;
  end

  always_ff @(posedge scl_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lnk <= '0;
    end
    else
    begin
      lnk <= next_lnk;
    end
  end

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // raw levels, no glitch filter beyond synchronisers
    two_wire = ctrl_in.wire_mode[1];
    ext_clk = ctrl_in.clock_source[1];
    scl_lvl = s.scl_sync[1];
    sda_lvl = s.sda_sync[1];
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.tgl_sync = {s.tgl_sync[1:0], lnk.rise_tgl};
    next_s.scl_prev = scl_lvl;
    rise = s.tgl_sync[2] ^ s.tgl_sync[1];
    fall = s.scl_prev & ~scl_lvl;
    // delayed data line so the clock level is settled at its edge
    next_s.sda_dly = {s.sda_dly[SSTWU_SDA_DELAY_CYC-2:0], sda_lvl};
    // detector gated by two-wire mode; runs on free clock
    start_det = two_wire & scl_lvl & s.sda_dly[SSTWU_SDA_DELAY_CYC-1]
                & ~s.sda_dly[SSTWU_SDA_DELAY_CYC-2];
    stop_det = two_wire & scl_lvl & ~s.sda_dly[SSTWU_SDA_DELAY_CYC-1]
               & s.sda_dly[SSTWU_SDA_DELAY_CYC-2];

    // edge choice by clock source, falling edge for shifting only with SSTWU_CS_EXT_NEG
    if (ext_clk)
    begin
      shift_tick = (ctrl_in.clock_source == SSTWU_CS_EXT_NEG) ? fall : rise;
    end
    else if (ctrl_in.clock_source == SSTWU_CS_TIMER)
    begin
      // timer match clocks the counter for a 12-bit chain
      shift_tick = timer_match_in;
    end
    else
    begin
      shift_tick = cmd_in.clock_strobe;
    end

    if (ext_clk)
    begin
      cnt_tick = ctrl_in.strobe_counts ? cmd_in.toggle_strobe : (rise | fall);
    end
    else
    begin
      cnt_tick = shift_tick;
    end
    in_bit = ext_clk ? lnk.sda_bit : sda_lvl;

    // shift in sampled bit; a write wins over a shift
    if (cmd_in.data_write)
    begin
      next_s.st.serial_shift_register = cmd_in.data_wdata;
    end
    else if (shift_tick)
    begin
      next_s.st.serial_shift_register = {s.st.serial_shift_register[SSTWU_MSB-1:0], in_bit};
    end

    // counter advances with every serial clock, or with the toggle strobe instead when strobe_counts is set
    wrap = cnt_tick & ~cmd_in.count_write & (s.st.count == SSTWU_COUNT_TOP);
    if (cmd_in.count_write)
    begin
      // software preset, e.g. 14 before the acknowledge
      next_s.st.count = cmd_in.count_wdata;
    end
    else if (cnt_tick)
    begin
      next_s.st.count = s.st.count + SSTWU_COUNT_STEP;
    end

    // wrap sets overflow; preset top gives one-edge event
    next_s.st.count_overflow_flag = wrap
      | (s.st.count_overflow_flag & ~cmd_in.clear_overflow);
    // start flag, set wins over clear
    next_s.st.start_detected_flag = start_det
      | (s.st.start_detected_flag & ~cmd_in.clear_start);
    next_s.st.stop_seen_flag = stop_det
      | (s.st.stop_seen_flag & ~cmd_in.clear_stop);

    // hold clock after start once the master pulls it low
    // clearing the start flag drops the hold
    next_s.start_hold = two_wire & next_s.st.start_detected_flag
                        & (s.start_hold | fall);

    // output latch: open while clock low under external clock
    if (!ext_clk || !scl_lvl)
    begin
      next_s.latch_msb = next_s.st.serial_shift_register[SSTWU_MSB];
    end
    next_s.st.collision = two_wire
      & (s.st.serial_shift_register[SSTWU_MSB] ^ sda_lvl);

    // slave only holds the clock; bytes run until stop
    // wait states: start hold or overflow hold in hold mode
    next_s.scl_oe = two_wire & (next_s.start_hold | port_scl_low_in
      | ((ctrl_in.wire_mode == SSTWU_WM_TWO_HOLD) & next_s.st.count_overflow_flag));
    // data pulled low when latched bit is zero
    next_s.sda_oe = two_wire & (~next_s.latch_msb | port_sda_low_in);
    next_s.scl_pin = 1'b0;
    next_s.sda_pin = 1'b0;
    next_s.data_pin = (ctrl_in.wire_mode == SSTWU_WM_THREE) & next_s.latch_msb;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
      s.scl_sync <= 2'h3;
      s.sda_sync <= 2'h3;
      s.sda_dly <= '1;
      s.scl_prev <= 1'b1;
      s.latch_msb <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign status_out = s.st;
  assign scl_out = s.scl_pin;
  assign scl_oe_out = s.scl_oe;
  assign sda_out = s.sda_pin;
  assign sda_oe_out = s.sda_oe;
  assign data_pin_out = s.data_pin;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ovf_on_wrap: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wrap |=> status_out.count_overflow_flag)
    else $error("overflow flag not set on wrap");

  a_ovf_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (cmd_in.clear_overflow && !wrap) |=> !status_out.count_overflow_flag)
    else $error("overflow flag not cleared");

  a_count_step: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (cnt_tick && !cmd_in.count_write)
      |=> status_out.count == $past(status_out.count) + SSTWU_COUNT_STEP)
    else $error("counter did not advance");

  a_start_set: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    start_det |=> status_out.start_detected_flag)
    else $error("start flag not set");

  a_start_mode: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_in.wire_mode[1] |-> !start_det && !stop_det)
    else $error("detector active outside two-wire mode");

  a_start_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (two_wire && status_out.start_detected_flag && fall && !cmd_in.clear_start)
      |=> scl_oe_out && s.start_hold)
    else $error("clock not held after start");

  a_hold_release: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(status_out.start_detected_flag) |-> !s.start_hold)
    else $error("start hold kept after clear");

  a_stop_set: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (stop_det ##1 !cmd_in.clear_stop) |=> status_out.stop_seen_flag)
    else $error("stop flag lost");

  a_ovf_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ctrl_in.wire_mode == SSTWU_WM_TWO_HOLD && wrap) |=> scl_oe_out)
    else $error("clock not held at overflow");

  a_no_drive_high: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !scl_out && !sda_out)
    else $error("line driven high");

  a_ack_low: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (two_wire && !next_s.latch_msb) |=> sda_oe_out)
    else $error("data not pulled for zero bit");

  a_shift_rise: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (shift_tick && !cmd_in.data_write)
      |=> status_out.serial_shift_register[0] == $past(in_bit))
    else $error("sampled bit not shifted in");

  a_lines_idle: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !two_wire |=> !scl_oe_out && !sda_oe_out)
    else $error("line pulled outside two-wire mode");

  a_hold_kept: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (ctrl_in.wire_mode == SSTWU_WM_TWO_HOLD && status_out.count_overflow_flag
      && !cmd_in.clear_overflow) |=> scl_oe_out)
    else $error("overflow hold dropped early");

  a_wrap_zero: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wrap |=> status_out.count == SSTWU_COUNT_RESET)
    else $error("counter not zero after wrap");

  a_start_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (cmd_in.clear_start && !start_det) |=> !status_out.start_detected_flag)
    else $error("start flag not cleared");

endmodule

// ===== bench/sstwu_master_model.sv
`timescale 1ns/1ps
module sstwu_master_model
(
  // bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // pull-low requests
  output logic scl_low_out,
  output logic sda_low_out
);
  logic last_bit;

  // clock made here, lines only pulled low
  initial
  begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
    last_bit = 1'b0;
  end

  task automatic rise();
    scl_low_out = 1'b0;
    for (int i = 0; i < 300 && scl_in !== 1'b1; i++) #10;
  endtask

  task automatic start();
    sda_low_out = 1'b1;
    #200;
    scl_low_out = 1'b1;
    #80;
  endtask

  task automatic send_bit(input logic b);
    sda_low_out = ~b;
    #80;
    rise();
    #40;
    last_bit = sda_in;
    #40;
    scl_low_out = 1'b1;
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    #80;
    rise();
    #200;
    sda_low_out = 1'b0;
    #200;
  endtask
endmodule

// ===== bench/serial_shift_two_wire_unit_tb.sv
`timescale 1ns/1ps
module serial_shift_two_wire_unit_tb;
  import sstwu_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in;
  logic timer_match = 1'b0;
  logic scl, sda, m_scl_low, m_sda_low, scl_oe, sda_oe;
  sstwu_ctrl_t ctrl = '0;
  sstwu_cmd_t cmd = '0;
  sstwu_status_t status;
  logic [18:0] obs;
  logic [37:0] q[$];
  logic [31:0] rnd = 32'h9705;
  logic [7:0] addr;
  logic [3:0] v;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  event ev;

  always #5 clk_in = ~clk_in;
  assign scl = ~(m_scl_low | scl_oe);
  assign sda = ~(m_sda_low | sda_oe);
  assign obs = {sstwu_master_model_inst.last_bit, scl_oe, sda_oe, status};

  sstwu_core sstwu_core_inst
  (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_clk_in(scl),
    .ctrl_in(ctrl), .cmd_in(cmd), .timer_match_in(timer_match),
    .port_scl_low_in(1'b0), .port_sda_low_in(1'b0), .status_out(status),
    .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .data_pin_out()
  );

  sstwu_master_model sstwu_master_model_inst
  (
    .scl_in(scl), .sda_in(sda), .scl_low_out(m_scl_low), .sda_low_out(m_sda_low)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [18:0] m, input logic [18:0] e);
    q.push_back({m, e});
    ->ev;
  endtask

  always @(ev)
  begin
    while (q.size() > 0)
    begin
      compares++;
      if ((obs & q[0][37:19]) !== q[0][18:0])
      begin
        n_errors++;
        $display("mismatch at %0t: got %h exp %h", $time, obs & q[0][37:19], q[0][18:0]);
      end
      void'(q.pop_front());
    end
  end

  task automatic issue(input sstwu_cmd_t c);
    @(posedge clk_in);
    cmd <= c;
    @(posedge clk_in);
    cmd <= '0;
    @(negedge clk_in);
  endtask

  task automatic set_mode(input sstwu_wire_mode_t wm, input sstwu_clk_src_t cs);
    @(posedge clk_in);
    ctrl <= '{wire_mode: wm, clock_source: cs, strobe_counts: 1'b0};
  endtask

  task automatic wait_obs(input int b);
    for (int i = 0; i < 100 && obs[b] !== 1'b1; i++) @(negedge clk_in);
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk(19'h3ffff, 19'h0);
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 4'hf : rnd[3:0];
      set_mode(SSTWU_WM_OFF, i[0] ? SSTWU_CS_TIMER : SSTWU_CS_SOFT);
      issue('{count_write: 1'b1, count_wdata: v, default: '0});
      if (i[0])
      begin
        @(posedge clk_in);
        timer_match <= 1'b1;
        @(posedge clk_in);
        timer_match <= 1'b0;
        @(negedge clk_in);
      end
      else
        issue('{clock_strobe: 1'b1, default: '0});
      chk(19'h000f4, {11'h0, v + 4'h1, 1'b0, v == 4'hf, 2'b0});
      issue('{clear_overflow: 1'b1, default: '0});
      chk(19'h00004, 19'h0);
    end
    set_mode(SSTWU_WM_THREE, SSTWU_CS_EXT_POS);
    issue('{count_write: 1'b1, data_write: 1'b1, data_wdata: 8'hff, default: '0});
    sstwu_master_model_inst.start();
    sstwu_master_model_inst.send_bit(1'b1);
    sstwu_master_model_inst.stop();
    chk(19'h000f8, 19'h00040);
    set_mode(SSTWU_WM_TWO_HOLD, SSTWU_CS_EXT_NEG);
    for (int t = 0; t < 2; t++)
    begin
      rnd = lfsr(rnd);
      addr = rnd[7:0];
      issue('{data_write: 1'b1, data_wdata: 8'hff, clear_stop: 1'b1, default: '0});
      sstwu_master_model_inst.start();
      wait_obs(17);
      chk(19'h20008, 19'h20008);
      issue('{clear_start: 1'b1, count_write: 1'b1, data_write: 1'b1, data_wdata: 8'hff,
              default: '0});
      chk(19'h20008, 19'h0);
      for (int b = 7; b >= 0; b--) sstwu_master_model_inst.send_bit(addr[b]);
      wait_obs(2);
      chk(19'h2fff4, {3'b010, addr, 8'h04});
      if (t == 0)
      begin
        issue('{data_write: 1'b1, count_write: 1'b1, count_wdata: 4'he, default: '0});
        chk(19'h100f0, 19'h100e0);
        issue('{clear_overflow: 1'b1, default: '0});
        sstwu_master_model_inst.send_bit(1'b1);
        wait_obs(2);
        chk(19'h60005, 19'h20004);
      end
      else
      begin
        issue('{clear_overflow: 1'b1, default: '0});
        chk(19'h20000, 19'h0);
      end
      issue('{data_write: 1'b1, data_wdata: 8'hff, clear_overflow: 1'b1, default: '0});
      sstwu_master_model_inst.stop();
      chk(19'h00002, 19'h00002);
    end
    issue('{clear_stop: 1'b1, default: '0});
    chk(19'h00002, 19'h0);
    conclude();
  end
endmodule
